/* File: logic/aotm_regs.vh */
`ifndef AOTM_REGS_VH
`define AOTM_REGS_VH

// Register byte offsets on the AXI4-Lite bus.
`define AOTM_OFF_CTRL 8'h00
`define AOTM_OFF_PRE_HOURS 8'h04
`define AOTM_OFF_PRE_MIN 8'h08
`define AOTM_OFF_PRE_SEC 8'h0c
`define AOTM_OFF_IND_START 8'h10
`define AOTM_OFF_DATA_PTR 8'h14
`define AOTM_OFF_DATA_VAL 8'h18
`define AOTM_OFF_ACC_HOURS 8'h1c
`define AOTM_OFF_ACC_MIN 8'h20
`define AOTM_OFF_ACC_SEC 8'h24
`define AOTM_OFF_STATUS 8'h28
`define AOTM_OFF_INT_STAT 8'h2c
`define AOTM_OFF_INT_MASK 8'h30

// Control register fields.
`define AOTM_CTRL_HOLD_MODE 0
`define AOTM_CTRL_RST_UNUSED 1
`define AOTM_CTRL_INDIRECT 2
`define AOTM_CTRL_RESET 3'h0

// Status and interrupt fields.
`define AOTM_ST_OUT 0
`define AOTM_ST_ERR 1
`define AOTM_ST_RUN 2
`define AOTM_INT_OUT_RISE 0
`define AOTM_INT_ERR_RISE 1
`define AOTM_INT_HOUR_WRAP 2
`define AOTM_INT_MASK_RESET 3'h0

// Preset limits and indirect start word ranges.
`define AOTM_MAX_MIN_SEC 16'h003b
`define AOTM_IND_LOW_MAX 11'h3e5
`define AOTM_IND_HIGH_MIN 11'h3e8
`define AOTM_IND_HIGH_MAX 11'h7cd
`define AOTM_DATA_WORDS 2000
`define AOTM_SEC_ROLL 60

// Timing: one second at a 10 ns clock.
`define AOTM_SEC_NS 1000000000
`define AOTM_CLK_NS 10
`define AOTM_CYC_PER_SEC (`AOTM_SEC_NS / `AOTM_CLK_NS)

// AXI responses.
`define AOTM_RESP_OKAY 2'h0
`define AOTM_RESP_SLVERR 2'h2

`endif

/* File: logic/aotm_tick.v */
`timescale 1ns/10ps
// Produces a one-cycle tick every P_CYCLES enabled cycles; the partial count
// is kept while disabled so on time is not lost between runs.
module aotm_tick #(
   parameter P_CYCLES = 100000000,
   parameter P_W = 27
) (
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_clr,
   input wire i_en,
   output wire o_tick
);
   reg [P_W-1:0] cnt_r;

   assign o_tick = i_en & (cnt_r == P_CYCLES[P_W-1:0] - 1'b1);

   // Count enabled cycles; a clear restarts the second from zero.
   always @(posedge i_mclk) begin
      if (i_sys_rst || i_clr) begin
         cnt_r <= {P_W{1'b0}};
      end else if (o_tick) begin
         cnt_r <= {P_W{1'b0}};
      end else if (i_en) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule

/* File: logic/aotm_wrap.v */
`timescale 1ns/10ps
// Modulo counter used for seconds and minutes; carry is combinational.
module aotm_wrap #(
   parameter P_MOD = 60,
   parameter P_W = 6
) (
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_clr,
   input wire i_inc,
   output reg [P_W-1:0] o_val,
   output wire o_carry
);
   assign o_carry = i_inc & (o_val == P_MOD[P_W-1:0] - 1'b1);

   // Step on each increment and roll to zero at the modulus.
   always @(posedge i_mclk) begin
      if (i_sys_rst || i_clr) begin
         o_val <= {P_W{1'b0}};
      end else if (o_carry) begin
         o_val <= {P_W{1'b0}};
      end else if (i_inc) begin
         o_val <= o_val + 1'b1;
      end
   end
endmodule

/* File: logic/aotm_top.v */
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - While run is high and reset low, accumulate on time as h:m:s.
// - Output is high when the total is at or above the preset, except in reset, on an error, or in clear mode with run low.
// - Total and preset are each three words: hours, minutes, seconds.
// - Past 65535:59:59 the hours wrap modulo 65536.
// - A preset field out of range flags an error, forces output low, counting goes on.
// - Reset wins over run; no on time accumulates while reset is high.
// - While reset is high, total clears to zero and output goes low.
// - A reset input marked unused by control bit 1 behaves as permanently low.
// - Keep mode (default): output high at run fall stays high until reset.
// - Clear mode: output high at run fall is driven low.
// - Total holds while run is low and resumes from there.
// - Indirect preset: three data words from start word, start up to 997 or 1000..1997.
// - Constant preset: three consecutive slots hold hours, minutes, seconds.
`include "aotm_regs.vh"
module aotm_top #(
   parameter P_CYC_PER_SEC = `AOTM_CYC_PER_SEC,
   parameter P_DATA_WORDS = `AOTM_DATA_WORDS
) (
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_run,
   input wire i_acc_rst,
   output reg o_cmp_out,
   output wire o_irq,
   input wire [7:0] i_s_axi_awaddr,
   input wire i_s_axi_awvalid,
   output wire o_s_axi_awready,
   input wire [31:0] i_s_axi_wdata,
   input wire [3:0] i_s_axi_wstrb,
   input wire i_s_axi_wvalid,
   output wire o_s_axi_wready,
   output reg [1:0] o_s_axi_bresp,
   output reg o_s_axi_bvalid,
   input wire i_s_axi_bready,
   input wire [7:0] i_s_axi_araddr,
   input wire i_s_axi_arvalid,
   output wire o_s_axi_arready,
   output reg [31:0] o_s_axi_rdata,
   output reg [1:0] o_s_axi_rresp,
   output reg o_s_axi_rvalid,
   input wire i_s_axi_rready
);
   // Control and configuration registers.
   reg [2:0] ctrl_r;
   reg [15:0] pre_hours_r;
   reg [15:0] pre_min_r;
   reg [15:0] pre_sec_r;
   reg [10:0] ind_start_r;
   reg [10:0] data_ptr_r;
   reg [15:0] data_mem [0:P_DATA_WORDS-1];
   reg [2:0] int_stat_r;
   reg [2:0] int_mask_r;

   // Accumulator and output state.
   reg [15:0] acc_hours_r;
   reg run_d_r;
   reg keep_r;
   reg err_r;
   reg out_nxt;
   reg keep_nxt;
   wire [5:0] acc_min;
   wire [5:0] acc_sec;
   wire sec_tick;
   wire sec_carry;
   wire min_carry;

   // AXI write channel holding registers.
   reg aw_got_r;
   reg w_got_r;
   reg [7:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;

   // Effective reset: when software marks the input unused it reads as low.
   wire rst_eff = i_acc_rst & ~ctrl_r[`AOTM_CTRL_RST_UNUSED];
   wire count_en = i_run & ~rst_eff;
   wire clear_mode = ctrl_r[`AOTM_CTRL_HOLD_MODE];
   wire run_fall = run_d_r & ~i_run;

   // One-second time base; the fraction of a second is held while run is low.
   aotm_tick #(
      .P_CYCLES(P_CYC_PER_SEC),
      .P_W(32)
   ) u_tick (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_clr(rst_eff),
      .i_en(count_en),
      .o_tick(sec_tick)
   );

   // Seconds and minutes words, each rolling over at 60.
   aotm_wrap #(
      .P_MOD(`AOTM_SEC_ROLL),
      .P_W(6)
   ) u_sec (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_clr(rst_eff),
      .i_inc(sec_tick),
      .o_val(acc_sec),
      .o_carry(sec_carry)
   );

   aotm_wrap #(
      .P_MOD(`AOTM_SEC_ROLL),
      .P_W(6)
   ) u_min (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_clr(rst_eff),
      .i_inc(sec_carry),
      .o_val(acc_min),
      .o_carry(min_carry)
   );

   wire hour_wrap = min_carry & (acc_hours_r == 16'hffff);

   // Hours word; natural 16-bit overflow drops 65536 hours.
   always @(posedge i_mclk) begin
      if (i_sys_rst || rst_eff) begin
         acc_hours_r <= 16'h0000;
      end else if (min_carry) begin
         acc_hours_r <= acc_hours_r + 16'h0001;
      end
   end

   // Indirect start word must fall in one of the two legal windows.
   wire ind_sel = ctrl_r[`AOTM_CTRL_INDIRECT];
   wire ind_ok = (ind_start_r <= `AOTM_IND_LOW_MAX) ||
                 ((ind_start_r >= `AOTM_IND_HIGH_MIN) &&
                  (ind_start_r <= `AOTM_IND_HIGH_MAX));
   wire [10:0] ind_base = ind_ok ? ind_start_r : 11'h000;

   // Preset words in hours, minutes, seconds order from either source.
   wire [15:0] p_hours = ind_sel ? data_mem[ind_base] : pre_hours_r;
   wire [15:0] p_min = ind_sel ? data_mem[ind_base + 11'h001] : pre_min_r;
   wire [15:0] p_sec = ind_sel ? data_mem[ind_base + 11'h002] : pre_sec_r;

   // Hours cannot exceed its range in a 16-bit word, so only minutes,
   // seconds and the start word are checked.
   wire err_now = (p_min > `AOTM_MAX_MIN_SEC) || (p_sec > `AOTM_MAX_MIN_SEC) ||
                  (ind_sel & ~ind_ok);

   // Total versus preset as one wide number; only meaningful without error.
   wire ge = {acc_hours_r, acc_min, acc_sec} >=
             {p_hours, p_min[5:0], p_sec[5:0]};

   // Next output and keep latch. Reset and error both force low; keep mode
   // latches a high output across the run falling edge.
   always @* begin
      keep_nxt = keep_r;
      out_nxt = 1'b0;
      if (rst_eff) begin
         keep_nxt = 1'b0;
         out_nxt = 1'b0;
      end else begin
         if (run_fall && o_cmp_out && !clear_mode) begin
            keep_nxt = 1'b1;
         end
         if (err_now) begin
            out_nxt = 1'b0;
         end else if (keep_nxt) begin
            out_nxt = 1'b1;
         end else if (clear_mode && !i_run) begin
            out_nxt = 1'b0;
         end else begin
            out_nxt = ge;
         end
      end
   end

   // Output, error flag and run history all move on the block clock.
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_cmp_out <= 1'b0;
         keep_r <= 1'b0;
         err_r <= 1'b0;
         run_d_r <= 1'b0;
      end else begin
         o_cmp_out <= out_nxt;
         keep_r <= keep_nxt;
         err_r <= err_now;
         run_d_r <= i_run;
      end
   end

   // Interrupt events: output rising, error rising, hours wrapping.
   wire [2:0] int_ev = {hour_wrap, err_now & ~err_r, out_nxt & ~o_cmp_out};
   assign o_irq = |(int_stat_r & int_mask_r);

   // AXI handshakes: each address/data beat is taken once and held until
   // the write completes, so the two may arrive in either order.
   assign o_s_axi_awready = ~aw_got_r & ~o_s_axi_bvalid;
   assign o_s_axi_wready = ~w_got_r & ~o_s_axi_bvalid;
   assign o_s_axi_arready = ~o_s_axi_rvalid;
   wire wr_do = aw_got_r & w_got_r;
   wire rd_do = i_s_axi_arvalid & o_s_axi_arready;
   wire rd_stat = rd_do && (i_s_axi_araddr == `AOTM_OFF_INT_STAT);
   wire [15:0] strb_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   wire [15:0] wd = w_data_r[15:0];

   // Byte-lane merge of a 16-bit register with the held write data.
   function [15:0] merge;
      input [15:0] old;
      input [15:0] dat;
      input [15:0] msk;
      begin
         merge = (old & ~msk) | (dat & msk);
      end
   endfunction

   // Start word and pointer keep only their low 11 bits of the merged word.
   wire [15:0] ind_start_m = merge({5'h00, ind_start_r}, wd, strb_mask);
   wire [15:0] data_ptr_m = merge({5'h00, data_ptr_r}, wd, strb_mask);

   // Write channel capture and register updates; unmapped writes are
   // dropped with SLVERR.
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= `AOTM_RESP_OKAY;
         ctrl_r <= `AOTM_CTRL_RESET;
         pre_hours_r <= 16'h0000;
         pre_min_r <= 16'h0000;
         pre_sec_r <= 16'h0000;
         ind_start_r <= 11'h000;
         data_ptr_r <= 11'h000;
         int_mask_r <= `AOTM_INT_MASK_RESET;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_got_r <= 1'b1;
            aw_addr_r <= i_s_axi_awaddr;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_got_r <= 1'b1;
            w_data_r <= i_s_axi_wdata;
            w_strb_r <= i_s_axi_wstrb;
         end
         if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
         end
         if (wr_do) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= `AOTM_RESP_OKAY;
            if (aw_addr_r == `AOTM_OFF_CTRL) begin
               if (w_strb_r[0]) begin
                  ctrl_r <= w_data_r[2:0];
               end
            end else if (aw_addr_r == `AOTM_OFF_PRE_HOURS) begin
               pre_hours_r <= merge(pre_hours_r, wd, strb_mask);
            end else if (aw_addr_r == `AOTM_OFF_PRE_MIN) begin
               pre_min_r <= merge(pre_min_r, wd, strb_mask);
            end else if (aw_addr_r == `AOTM_OFF_PRE_SEC) begin
               pre_sec_r <= merge(pre_sec_r, wd, strb_mask);
            end else if (aw_addr_r == `AOTM_OFF_IND_START) begin
               ind_start_r <= ind_start_m[10:0];
            end else if (aw_addr_r == `AOTM_OFF_DATA_PTR) begin
               data_ptr_r <= data_ptr_m[10:0];
            end else if (aw_addr_r == `AOTM_OFF_DATA_VAL) begin
               o_s_axi_bresp <= `AOTM_RESP_OKAY;
            end else if (aw_addr_r == `AOTM_OFF_INT_MASK) begin
               if (w_strb_r[0]) begin
                  int_mask_r <= w_data_r[2:0];
               end
            end else if ((aw_addr_r == `AOTM_OFF_ACC_HOURS) ||
                         (aw_addr_r == `AOTM_OFF_ACC_MIN) ||
                         (aw_addr_r == `AOTM_OFF_ACC_SEC) ||
                         (aw_addr_r == `AOTM_OFF_STATUS) ||
                         (aw_addr_r == `AOTM_OFF_INT_STAT)) begin
               o_s_axi_bresp <= `AOTM_RESP_OKAY;
            end else begin
               o_s_axi_bresp <= `AOTM_RESP_SLVERR;
            end
         end
      end
   end

   // Data word store; no reset, so software must fill words before use.
   always @(posedge i_mclk) begin
      if (wr_do && (aw_addr_r == `AOTM_OFF_DATA_VAL) &&
          (data_ptr_r < P_DATA_WORDS)) begin
         data_mem[data_ptr_r] <= merge(data_mem[data_ptr_r], wd, strb_mask);
      end
   end

   // Sticky interrupt status; a new event in the reading cycle survives.
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         int_stat_r <= 3'h0;
      end else if (rd_stat) begin
         int_stat_r <= int_ev;
      end else begin
         int_stat_r <= int_stat_r | int_ev;
      end
   end

   // Read channel: one cycle from address to data.
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h00000000;
         o_s_axi_rresp <= `AOTM_RESP_OKAY;
      end else if (rd_do) begin
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rresp <= `AOTM_RESP_OKAY;
         if (i_s_axi_araddr == `AOTM_OFF_CTRL) begin
            o_s_axi_rdata <= {29'h0, ctrl_r};
         end else if (i_s_axi_araddr == `AOTM_OFF_PRE_HOURS) begin
            o_s_axi_rdata <= {16'h0000, pre_hours_r};
         end else if (i_s_axi_araddr == `AOTM_OFF_PRE_MIN) begin
            o_s_axi_rdata <= {16'h0000, pre_min_r};
         end else if (i_s_axi_araddr == `AOTM_OFF_PRE_SEC) begin
            o_s_axi_rdata <= {16'h0000, pre_sec_r};
         end else if (i_s_axi_araddr == `AOTM_OFF_IND_START) begin
            o_s_axi_rdata <= {21'h0, ind_start_r};
         end else if (i_s_axi_araddr == `AOTM_OFF_DATA_PTR) begin
            o_s_axi_rdata <= {21'h0, data_ptr_r};
         end else if (i_s_axi_araddr == `AOTM_OFF_DATA_VAL) begin
            if (data_ptr_r < P_DATA_WORDS) begin
               o_s_axi_rdata <= {16'h0000, data_mem[data_ptr_r]};
            end else begin
               o_s_axi_rdata <= 32'h00000000;
            end
         end else if (i_s_axi_araddr == `AOTM_OFF_ACC_HOURS) begin
            o_s_axi_rdata <= {16'h0000, acc_hours_r};
         end else if (i_s_axi_araddr == `AOTM_OFF_ACC_MIN) begin
            o_s_axi_rdata <= {26'h0, acc_min};
         end else if (i_s_axi_araddr == `AOTM_OFF_ACC_SEC) begin
            o_s_axi_rdata <= {26'h0, acc_sec};
         end else if (i_s_axi_araddr == `AOTM_OFF_STATUS) begin
            o_s_axi_rdata <= {29'h0, i_run, err_r, o_cmp_out};
         end else if (i_s_axi_araddr == `AOTM_OFF_INT_STAT) begin
            o_s_axi_rdata <= {29'h0, int_stat_r};
         end else if (i_s_axi_araddr == `AOTM_OFF_INT_MASK) begin
            o_s_axi_rdata <= {29'h0, int_mask_r};
         end else begin
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= `AOTM_RESP_SLVERR;
         end
      end else if (i_s_axi_rready) begin
         o_s_axi_rvalid <= 1'b0;
      end
   end
endmodule

/* File: tb/aotm_prog_model.sv */
`timescale 1ns/10ps
// Stand-in for the user program that drives the run and reset inputs.
module aotm_prog_model (
   input wire i_mclk,
   output logic o_run,
   output logic o_acc_rst
);
   initial begin
      o_run = 1'b0;
      o_acc_rst = 1'b0;
   end
   // Run is held for exactly n sampling edges, so the counted on time is known.
   task automatic run_for(input int n);
      @(posedge i_mclk);
      o_run <= 1'b1;
      repeat (n) @(posedge i_mclk);
      o_run <= 1'b0;
   endtask
   // Reset may be raised with run high too, to show that reset wins.
   task automatic clr_for(input int n, input logic run);
      @(posedge i_mclk);
      o_acc_rst <= 1'b1;
      o_run <= run;
      repeat (n) @(posedge i_mclk);
      o_acc_rst <= 1'b0;
      o_run <= 1'b0;
   endtask
endmodule

/* File: tb/aotm_top_checker.sv */
`timescale 1ns/10ps
// Port-level checks; the two control bits are tracked from the bus traffic.
module aotm_top_checker (
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_run,
   input wire i_acc_rst,
   input wire o_cmp_out,
   input wire o_irq,
   input wire [7:0] i_s_axi_awaddr,
   input wire i_s_axi_awvalid,
   input wire o_s_axi_awready,
   input wire [31:0] i_s_axi_wdata,
   input wire i_s_axi_wvalid,
   input wire o_s_axi_wready,
   input wire o_s_axi_bvalid,
   input wire i_s_axi_bready,
   input wire i_s_axi_arvalid,
   input wire o_s_axi_arready,
   input wire o_s_axi_rvalid,
   input wire i_s_axi_rready
);
   logic pend_r;
   logic [1:0] pend_d_r;
   logic [1:0] ctl_r;
   // The control word lands one edge after its beats are taken, so the copy waits too.
   always @(posedge i_mclk) begin
      pend_d_r <= i_s_axi_wdata[1:0];
      if (i_sys_rst) begin
         pend_r <= 1'b0;
         ctl_r <= 2'h0;
      end else begin
         pend_r <= i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
                   && i_s_axi_awaddr == 8'h00;
         if (pend_r) begin
            ctl_r <= pend_d_r;
         end
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   sequence s_wr_take;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
   endsequence
   sequence s_rd_take;
      i_s_axi_arvalid && o_s_axi_arready;
   endsequence
   a_reset_idle: assert property (
      $fell(i_sys_rst) |-> !o_cmp_out && !o_irq && !o_s_axi_bvalid && !o_s_axi_rvalid)
      else $error("outputs not idle after reset");
   a_wr_answer: assert property (s_wr_take |=> !o_s_axi_bvalid ##1 o_s_axi_bvalid)
      else $error("write response not two edges after take");
   a_rd_answer: assert property (s_rd_take |=> o_s_axi_rvalid)
      else $error("read data not one edge after take");
   a_b_release: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
      else $error("write response held after handshake");
   a_r_release: assert property (
      o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid && o_s_axi_arready)
      else $error("read data held after handshake");
   a_acc_clear: assert property (i_acc_rst && !ctl_r[1] |=> !o_cmp_out)
      else $error("output high after reset input");
   a_keep_hold: assert property (
      !ctl_r[0] && o_cmp_out && $fell(i_run) && !i_acc_rst |=> o_cmp_out [*4])
      else $error("kept output dropped");
   a_clear_low: assert property (ctl_r[0] && !i_run |=> !o_cmp_out)
      else $error("output high with run low in clear mode");
endmodule
bind aotm_top aotm_top_checker u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
   .i_run(i_run), .i_acc_rst(i_acc_rst), .o_cmp_out(o_cmp_out), .o_irq(o_irq),
   .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
   .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
   .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
   .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
   .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
   .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready));

/* File: tb/aotm_top_tb.sv */
`timescale 1ns/10ps
// Bench: AXI4-Lite master tasks, a program-side driver and expected values.
module aotm_top_tb;
   localparam int CPS = 4;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, run, acc_rst, cmp_out, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int miscompares = 0;
   int num_checks = 0;
   int starts[6] = '{997, 998, 999, 1000, 1997, 1998};
   logic [5:0] good = 6'b011001;
   int k;
   always #5 clk = ~clk;
   aotm_prog_model prog (.i_mclk(clk), .o_run(run), .o_acc_rst(acc_rst));
   aotm_top #(.P_CYC_PER_SEC(CPS), .P_DATA_WORDS(2000)) dut (.i_mclk(clk),
      .i_sys_rst(sys_rst), .i_run(run), .i_acc_rst(acc_rst), .o_cmp_out(cmp_out),
      .o_irq(irq), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf),
      .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
      .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
      .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
      .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Handshakes are judged on values settled at mid-cycle, which equal those at the edge.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      logic aw_ok, w_ok, b_ok;
      logic [1:0] r;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_ok = 1'b0;
      while (!b_ok) begin
         @(negedge clk);
         aw_ok = awvalid && awready;
         w_ok = wvalid && wready;
         b_ok = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk("bvalid", 32'h1, {31'h0, b_ok});
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0,
                     input bit look = 1'b1);
      logic a_ok, r_ok;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_ok = 1'b0;
      while (!r_ok) begin
         @(negedge clk);
         a_ok = arvalid && arready;
         r_ok = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (a_ok) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      chk("rvalid", 32'h1, {31'h0, r_ok});
      if (look) chk("rdata", exp, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask
   task automatic tot(input logic [31:0] h, input logic [31:0] m, input logic [31:0] s);
      rd(8'h1c, h);
      rd(8'h20, m);
      rd(8'h24, s);
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // The hour carry alone takes about 14400 cycles; the limit leaves ample margin.
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      complete_run;
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h30, 32'h0);
      chk("out zero preset", 32'h1, {31'h0, cmp_out});
      rd(8'h34, 32'h0, 2'h2);
      wr(8'h34, 32'h1, 2'h2);
      wr(8'h1c, 32'h5);
      rd(8'h1c, 32'h0);
      // Minute and hour carries at their exact boundaries against a 1:00:00 preset.
      wr(8'h04, 32'h1);
      prog.clr_for(2, 1'b0);
      prog.run_for(60 * CPS);
      settle;
      tot(0, 1, 0);
      prog.run_for(3540 * CPS - 1);
      settle;
      tot(0, 59, 59);
      chk("out below preset", 32'h0, {31'h0, cmp_out});
      prog.run_for(1);
      settle;
      tot(1, 0, 0);
      chk("out at preset", 32'h1, {31'h0, cmp_out});
      // With the reset input unused, a pulse on it changes nothing.
      wr(8'h00, 32'h2);
      prog.clr_for(3, 1'b0);
      settle;
      chk("out reset unused", 32'h1, {31'h0, cmp_out});
      rd(8'h1c, 32'h1);
      wr(8'h00, 32'h0);
      // Partial seconds survive a pause; the kept output survives run falling.
      wr(8'h04, 32'h0);
      wr(8'h0c, 32'h2);
      prog.clr_for(2, 1'b0);
      prog.run_for(2 * CPS - 1);
      settle;
      rd(8'h24, 32'h1);
      chk("out before resume", 32'h0, {31'h0, cmp_out});
      prog.run_for(1);
      settle;
      rd(8'h24, 32'h2);
      prog.run_for(2);
      settle;
      chk("out kept", 32'h1, {31'h0, cmp_out});
      prog.clr_for(2 * CPS, 1'b1);
      settle;
      chk("out after reset", 32'h0, {31'h0, cmp_out});
      tot(0, 0, 0);
      // Clear mode drops the output as soon as run falls.
      wr(8'h00, 32'h1);
      prog.run_for(2 * CPS + 2);
      @(negedge clk);
      chk("out clear run", 32'h1, {31'h0, cmp_out});
      settle;
      chk("out clear fall", 32'h0, {31'h0, cmp_out});
      wr(8'h00, 32'h0);
      // A bad seconds field forces the output low while counting and the error event go on.
      prog.clr_for(2, 1'b0);
      rd(8'h2c, 32'h0, 2'h0, 1'b0);
      wr(8'h0c, 32'h40);
      prog.run_for(2 * CPS);
      settle;
      chk("out preset error", 32'h0, {31'h0, cmp_out});
      rd(8'h24, 32'h2);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(8'h30, 32'h2);
      settle;
      chk("irq unmasked", 32'h1, {31'h0, irq});
      rd(8'h2c, 32'h2);
      settle;
      chk("irq after read", 32'h0, {31'h0, irq});
      wr(8'h0c, 32'h1);
      settle;
      chk("out error gone", 32'h1, {31'h0, cmp_out});
      chk("irq rise masked", 32'h0, {31'h0, irq});
      // Indirect preset: start word ranges, then the order of the three words.
      prog.clr_for(2, 1'b0);
      foreach (starts[i]) begin
         for (k = 0; k < 3 && good[i]; k++) begin
            wr(8'h14, 32'(starts[i] + k));
            wr(8'h18, 32'h0);
         end
      end
      // Point at written words first, so the unreset word store feeds the compare only for the rejected start words.
      wr(8'h10, 32'd997);
      wr(8'h00, 32'h4);
      foreach (starts[i]) begin
         wr(8'h10, 32'(starts[i]));
         settle;
         chk("out start word", {31'h0, good[i]}, {31'h0, cmp_out});
      end
      wr(8'h14, 32'd1002);
      wr(8'h18, 32'h1);
      wr(8'h10, 32'd1000);
      settle;
      chk("out indirect low", 32'h0, {31'h0, cmp_out});
      prog.run_for(CPS);
      settle;
      chk("out indirect met", 32'h1, {31'h0, cmp_out});
      // A second reset after the run has ended returns the registers to zero.
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h10, 32'h0);
      complete_run;
   end
endmodule
